// ==== pkg/ovp_consts.svh ====
/*
  constants of the overvoltage pick-up stage: register offsets, field widths,
  reset values and timing figures.
  assumes it is included by bare name wherever a constant is used.
*/
`ifndef OVP_CONSTS_SVH
`define OVP_CONSTS_SVH

// ************************************************************
// timing
// ************************************************************
`define CLK_HZ 20000000
`define TIME_BASE_US 5000
`define PREFAULT_WIN_US 20000
`define AVG_DEPTH (`PREFAULT_WIN_US / `TIME_BASE_US)
`define AVG_AW 2

// ************************************************************
// register byte offsets
// ************************************************************
`define REG_CTRL 8'h00
`define REG_FORCE 8'h04
`define REG_THRESH 8'h08
`define REG_VT_PRIM 8'h0c
`define REG_DELAY 8'h10
`define REG_STATUS 8'h14
`define REG_RATIO_A 8'h18
`define REG_RATIO_B 8'h1c
`define REG_RATIO_C 8'h20
`define REG_RATIO_SEL 8'h24
`define REG_PRIM_THR 8'h28
`define REG_EXP_TIME 8'h2c
`define REG_REMAIN 8'h30
`define REG_PREFAULT 8'h34

// ************************************************************
// fields and reset values
// ************************************************************
`define CTRL_W 5
`define FORCE_W 3
`define THRESH_RST 16'h2904
`define VT_PRIM_RST 20'h00064
`define DELAY_RST 19'h00008
`define HYST_PCT 24'h000061
`define FULL_PCT 24'h000064
`define PRIM_DIV 36'h0000003e8
`define RATIO_MAX 17'h1ffff

`endif

// ==== pkg/ovp_pkg.sv ====
/*
  types of the overvoltage pick-up stage.
  assumes ovp_consts.svh carries the numbers.
*/
package ovp_pkg;

  typedef enum logic [1:0] {
    SEL_PP,
    SEL_PE,
    SEL_CH3,
    SEL_CH4
  } mag_sel_e;

  typedef enum logic [1:0] {
    CRIT_ONE,
    CRIT_TWO,
    CRIT_ALL,
    CRIT_RSVD
  } crit_e;

  typedef enum logic [1:0] {
    FRC_NORMAL,
    FRC_START,
    FRC_TRIP,
    FRC_BLOCKED
  } force_e;

  // magnitudes in 0.01 % of nominal_voltage
  typedef struct packed {
    logic [2:0][15:0] ll;
    logic [2:0][15:0] ln;
    logic [15:0] ch3;
    logic [15:0] ch4;
  } meas_s;

  typedef struct packed {
    crit_e crit;
    logic two_line_ch3_wiring;
    mag_sel_e sel;
  } ctrl_s;

  typedef struct packed {
    logic en;
    force_e status;
  } force_s;

endpackage

// ==== rtl/ov_avg_mem.sv ====
/*
  small ring memory for the pre-fault history of the selected magnitude.
  assumes the writer holds the address stable between writes; read data
  come out of a register one cycle after the address.
*/
`timescale 1ns/10ps
`include "ovp_consts.svh"

module ov_avg_mem (
  // clock
  input wire logic clk_i,
  // access
  input wire logic we_i,
  input wire logic [`AVG_AW-1:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o
);

  logic [15:0] mem [`AVG_DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_o <= mem[addr_i];
  end

endmodule

// ==== rtl/overvoltage_pickup_stage.sv ====
/*
  input selection and pick-up stage of an overvoltage function, with
  forcing, ratio and timing indications, reached over classic wishbone.
  assumes meas_valid_i pulses once per 5 ms update from logic on clk_i
  and block_i comes from outside the clock domain.
*/
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
`include "ovp_consts.svh"

// Contract
// - work on six rms magnitudes refreshed every 5 ms
// - selector: 0 phase-phase, 1 phase-earth, 2 channel three, 3 channel four
// - phase selections use three channels, only two in two-line wiring
// - channel four always used; channel three only in two-line wiring
// - record 20 ms average of selected magnitude at start or trip
// - force status overrides outputs only while forcing is enabled
// - force status is static, untouched by setting group changes
// - each selected magnitude above threshold flags phase pick-up
// - phase pick-up drops only below 97 percent of threshold
// - criterion needs one, two or all three phases picked up
// - threshold in 0.01 percent of nominal, default 105 percent
// - one threshold shared by all phases
// - start only while blocking input is inactive
// - expected operating time shown in 5 ms steps
// - signed remaining time to trip in 5 ms steps
// - ratio of magnitude to threshold per phase and selected
// - threshold in primary volts at 0.1 V resolution
// - blocking sampled at start of each processing cycle
// - blocked pick-up gives blocked not start; active start resets
// - outputs start, trip and blocked; trip_o is set only by forcing and stays low otherwise
module overvoltage_pickup_stage (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // measurement and blocking
  input wire ovp_pkg::meas_s meas_i,
  input wire logic meas_valid_i,
  input wire logic block_i,
  // stage outputs
  output logic start_o,
  output logic trip_o,
  output logic blocked_o
);

  // ************************************************************
  // registers
  // ************************************************************
  ovp_pkg::ctrl_s ctrl;
  ovp_pkg::force_s frc;
  logic [15:0] thresh;
  logic [19:0] vt_prim;
  logic [18:0] delay;
  logic wr;
  logic [31:0] wmask;

  assign wr = cyc_i & stb_i & we_i & ~ack_o;
  assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}},
                  {8{sel_i[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (dat_i & wmask);
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= '0;
      thresh <= `THRESH_RST;
      vt_prim <= `VT_PRIM_RST;
      delay <= `DELAY_RST;
    end else if (wr) begin
      case (adr_i)
        `REG_CTRL: ctrl <= ovp_pkg::ctrl_s'(`CTRL_W'(merge(32'(ctrl))));
        `REG_THRESH: thresh <= 16'(merge(32'(thresh)));
        `REG_VT_PRIM: vt_prim <= 20'(merge(32'(vt_prim)));
        `REG_DELAY: delay <= 19'(merge(32'(delay)));
        default: ;
      endcase
    end
  end

  // kept apart from the setting registers so no group change reaches it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frc <= '0;
    end else if (wr && adr_i == `REG_FORCE) begin
      frc <= ovp_pkg::force_s'(`FORCE_W'(merge(32'(frc))));
    end
  end

  // ************************************************************
  // blocking input synchroniser
  // ************************************************************
  logic blk_s1;
  logic blk_s2;
  logic blk_s3;
  logic blk_filt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blk_s1 <= 1'b0;
      blk_s2 <= 1'b0;
      blk_s3 <= 1'b0;
      blk_filt <= 1'b0;
    end else begin
      blk_s1 <= block_i;
      blk_s2 <= blk_s1;
      blk_s3 <= blk_s2;
      if (blk_s2 == blk_s3) begin
        blk_filt <= blk_s3;
      end
    end
  end

  // ************************************************************
  // stage 1: input selection and block sampling
  // ************************************************************
  logic [2:0][15:0] sel_mag;
  logic blk_smp;
  logic upd_d;
  logic upd_d2;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_mag <= '0;
      blk_smp <= 1'b0;
      upd_d <= 1'b0;
      upd_d2 <= 1'b0;
    end else begin
      upd_d <= meas_valid_i;
      upd_d2 <= upd_d;
      if (meas_valid_i) begin
        blk_smp <= blk_filt;
        case (ctrl.sel)
          ovp_pkg::SEL_PP: begin
            sel_mag <= meas_i.ll;
            if (ctrl.two_line_ch3_wiring) begin
              sel_mag[2] <= '0;
            end
          end
          ovp_pkg::SEL_PE: begin
            sel_mag <= meas_i.ln;
            if (ctrl.two_line_ch3_wiring) begin
              sel_mag[2] <= '0;
            end
          end
          ovp_pkg::SEL_CH3: begin
            sel_mag <= ctrl.two_line_ch3_wiring ? {3{meas_i.ch3}} : '0;
          end
          default: sel_mag <= {3{meas_i.ch4}};
        endcase
      end
    end
  end

  // ************************************************************
  // stage 2: per-phase comparison and ratios
  // ************************************************************
  logic [2:0] pickup;
  logic [2:0][16:0] ratio;
  logic [16:0] ratio_sel;
  logic [23:0] thr_full;
  logic [23:0] thr_drop;

  assign thr_full = 24'(thresh) * `FULL_PCT;
  assign thr_drop = 24'(thresh) * `HYST_PCT;

  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic [23:0] mag_x;
    assign mag_x = 24'(sel_mag[p]) * `FULL_PCT;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pickup[p] <= 1'b0;
        ratio[p] <= '0;
      end else if (upd_d) begin
        if (mag_x > thr_full) begin
          pickup[p] <= 1'b1;
        end else if (mag_x < thr_drop) begin
          pickup[p] <= 1'b0;
        end
        ratio[p] <= (thresh == 16'h0000) ? `RATIO_MAX :
                    17'(mag_x / 24'(thresh));
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ratio_sel <= '0;
    end else if (upd_d2) begin
      ratio_sel <= (ratio[0] > ratio[1]) ?
                   ((ratio[0] > ratio[2]) ? ratio[0] : ratio[2]) :
                   ((ratio[1] > ratio[2]) ? ratio[1] : ratio[2]);
    end
  end

  // ************************************************************
  // stage 3: criterion, blocking and outputs
  // ************************************************************
  logic [1:0] n_pick;
  logic stage_pick;
  logic start_e;
  logic blocked_e;

  assign n_pick = 2'(pickup[0]) + 2'(pickup[1]) + 2'(pickup[2]);

  always_comb begin
    case (ctrl.crit)
      ovp_pkg::CRIT_ONE: stage_pick = n_pick >= 2'h1;
      ovp_pkg::CRIT_TWO: stage_pick = n_pick >= 2'h2;
      default: stage_pick = n_pick == 2'h3;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_e <= 1'b0;
      blocked_e <= 1'b0;
    end else if (upd_d2) begin
      start_e <= stage_pick & ~blk_smp;
      blocked_e <= stage_pick & blk_smp;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_o <= 1'b0;
      trip_o <= 1'b0;
      blocked_o <= 1'b0;
    end else if (frc.en) begin
      start_o <= frc.status == ovp_pkg::FRC_START ||
                 frc.status == ovp_pkg::FRC_TRIP;
      trip_o <= frc.status == ovp_pkg::FRC_TRIP;
      blocked_o <= frc.status == ovp_pkg::FRC_BLOCKED;
    end else begin
      start_o <= start_e;
      trip_o <= 1'b0;
      blocked_o <= blocked_e;
    end
  end

  // ************************************************************
  // pre-fault average
  // ************************************************************
  logic [`AVG_AW-1:0] avg_ptr;
  logic [15:0] avg_old;
  logic [15:0] avg_new;
  logic [15:0] avg_drop;
  logic avg_full;
  logic [17:0] avg_sum;
  logic [15:0] prefault;
  logic start_d;
  logic trip_d;

  assign avg_new = (sel_mag[0] > sel_mag[1]) ?
                   ((sel_mag[0] > sel_mag[2]) ? sel_mag[0] : sel_mag[2]) :
                   ((sel_mag[1] > sel_mag[2]) ? sel_mag[1] : sel_mag[2]);

  // ring words are unknown until written once, so nothing leaves before
  assign avg_drop = avg_full ? avg_old : 16'h0000;

  ov_avg_mem u_avg_mem (
    .clk_i(clk_i),
    .we_i(upd_d),
    .addr_i(avg_ptr),
    .wdata_i(avg_new),
    .rdata_o(avg_old)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      avg_ptr <= '0;
      avg_sum <= '0;
      avg_full <= 1'b0;
    end else if (upd_d) begin
      avg_ptr <= avg_ptr + `AVG_AW'(1);
      avg_sum <= avg_sum + 18'(avg_new) - 18'(avg_drop);
      if (avg_ptr == `AVG_AW'(`AVG_DEPTH - 1)) begin
        avg_full <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_d <= 1'b0;
      trip_d <= 1'b0;
      prefault <= '0;
    end else begin
      start_d <= start_o;
      trip_d <= trip_o;
      if ((start_o & ~start_d) | (trip_o & ~trip_d)) begin
        prefault <= avg_sum[17:`AVG_AW];
      end
    end
  end

  // ************************************************************
  // timing and scaled indications
  // ************************************************************
  logic [18:0] elapsed;
  logic [19:0] remain;
  logic [18:0] exp_time;
  logic [23:0] prim_thr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      elapsed <= '0;
      remain <= '0;
      exp_time <= '0;
      prim_thr <= '0;
    end else begin
      if (!start_o) begin
        elapsed <= '0;
      end else if (upd_d2) begin
        elapsed <= elapsed + 19'h00001;
      end
      if (upd_d2) begin
        exp_time <= delay;
        remain <= 20'(delay) - 20'(elapsed);
        prim_thr <= 24'((36'(thresh) * 36'(vt_prim)) / `PRIM_DIV);
      end
    end
  end

  // ************************************************************
  // wishbone read and acknowledge
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      case (adr_i)
        `REG_CTRL: dat_o <= 32'(ctrl);
        `REG_FORCE: dat_o <= 32'(frc);
        `REG_THRESH: dat_o <= 32'(thresh);
        `REG_VT_PRIM: dat_o <= 32'(vt_prim);
        `REG_DELAY: dat_o <= 32'(delay);
        `REG_STATUS: dat_o <= 32'({blk_smp, blocked_o, trip_o, start_o,
                                   stage_pick, pickup});
        `REG_RATIO_A: dat_o <= 32'(ratio[0]);
        `REG_RATIO_B: dat_o <= 32'(ratio[1]);
        `REG_RATIO_C: dat_o <= 32'(ratio[2]);
        `REG_RATIO_SEL: dat_o <= 32'(ratio_sel);
        `REG_PRIM_THR: dat_o <= 32'(prim_thr);
        `REG_EXP_TIME: dat_o <= 32'(exp_time);
        `REG_REMAIN: dat_o <= {{12{remain[19]}}, remain};
        `REG_PREFAULT: dat_o <= 32'(prefault);
        default: dat_o <= '0;
      endcase
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_start_unblocked;
    start_o && !frc.en && !$past(frc.en) |-> !$past(blk_smp, 3);
  endproperty
  a_start_unblocked: assert property (p_start_unblocked)
    else $error("start while blocking sampled");

  property p_blocked_not_start;
    blocked_o && !frc.en && !$past(frc.en) |-> !start_o;
  endproperty
  a_blocked_not_start: assert property (p_blocked_not_start)
    else $error("blocked and start together");

  property p_eval_cycle;
    !frc.en && !$past(frc.en) && !$past(frc.en, 2) && $changed(start_o)
      |-> $past(upd_d2, 2);
  endproperty
  a_eval_cycle: assert property (p_eval_cycle)
    else $error("start changed outside an update");

  property p_force_trip;
    frc.en && frc.status == ovp_pkg::FRC_TRIP |=> trip_o && start_o;
  endproperty
  a_force_trip: assert property (p_force_trip)
    else $error("forced trip not shown");

  property p_no_trip_unforced;
    !frc.en |=> !trip_o;
  endproperty
  a_no_trip_unforced: assert property (p_no_trip_unforced)
    else $error("trip without forcing");

  property p_pick_rise;
    upd_d && 24'(sel_mag[0]) * `FULL_PCT > thr_full |=> pickup[0];
  endproperty
  a_pick_rise: assert property (p_pick_rise)
    else $error("phase pick-up missed");

  property p_pick_hold;
    upd_d && pickup[1] && 24'(sel_mag[1]) * `FULL_PCT >= thr_drop
      |=> pickup[1];
  endproperty
  a_pick_hold: assert property (p_pick_hold)
    else $error("pick-up dropped inside hysteresis");

  property p_crit_all;
    ctrl.crit == ovp_pkg::CRIT_ALL && $rose(start_e) |-> &$past(pickup);
  endproperty
  a_crit_all: assert property (p_crit_all)
    else $error("start without all phases");

  property p_block_sample;
    $changed(blk_smp) |-> $past(meas_valid_i);
  endproperty
  a_block_sample: assert property (p_block_sample)
    else $error("block sampled outside update");

  property p_sel_ch4;
    meas_valid_i && ctrl.sel == ovp_pkg::SEL_CH4
      |=> sel_mag[2] == $past(meas_i.ch4);
  endproperty
  a_sel_ch4: assert property (p_sel_ch4)
    else $error("channel four not selected");

  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");

  c_start: cover property ($rose(start_o) && !frc.en);
  c_blocked: cover property ($rose(blocked_o) && !frc.en);
  c_force: cover property (frc.en && frc.status == ovp_pkg::FRC_BLOCKED);
  c_prefault: cover property ($changed(prefault));

endmodule

// ==== tb/ovp_meas_model.sv ====
/*
  far-side model: measurement chain and blocking source of the stage.
  assumes the bench gives the wanted magnitudes and blocking level; the
  update period is shortened from 5 ms to PERIOD clock cycles.
*/
`timescale 1ns/10ps

module ovp_meas_model #(
  parameter int PERIOD = 40
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wanted values from the bench
  input wire ovp_pkg::meas_s mag_i,
  input wire logic block_req_i,
  // toward the stage
  output ovp_pkg::meas_s meas_o,
  output logic meas_valid_o,
  output logic block_o
);
  int cnt;

  // ************************************************************
  // periodic update of all six magnitudes and both channels
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      meas_valid_o <= 1'b0;
      meas_o <= '0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      meas_valid_o <= (cnt == PERIOD - 1);
      if (cnt == PERIOD - 1) begin
        meas_o <= mag_i;
      end
    end
  end

  // blocking matrix output, a plain level
  always_ff @(posedge clk_i) begin
    block_o <= block_req_i;
  end
endmodule

// ==== tb/overvoltage_pickup_stage_tb_top.sv ====
/*
  self-checking bench of the overvoltage pick-up stage.
  assumes the register map and latencies given in the stage's hand-over.
*/
`timescale 1ns/10ps
`include "ovp_consts.svh"

module overvoltage_pickup_stage_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  ovp_pkg::meas_s meas_i;
  ovp_pkg::meas_s mag = '0;
  logic meas_valid_i;
  logic block_i;
  logic block_req = 1'b0;
  logic start_o;
  logic trip_o;
  logic blocked_o;
  logic [31:0] exp_q[$];
  logic [2:0] cfg[6] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h3, 3'h5};
  logic [7:0] est[6] = '{8'h00, 8'h1f, 8'h00, 8'h1f, 8'h1f, 8'h1b};
  logic [2:0] fexp[4] = '{3'h0, 3'h4, 3'h6, 3'h1};
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 32'h5942;

  always #25 clk_i = ~clk_i;

  ovp_meas_model #(.PERIOD(40)) far (.clk_i(clk_i), .rst_i(rst_i),
    .mag_i(mag), .block_req_i(block_req), .meas_o(meas_i),
    .meas_valid_o(meas_valid_i), .block_o(block_i));

  overvoltage_pickup_stage uut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .meas_i(meas_i), .meas_valid_i(meas_valid_i), .block_i(block_i),
    .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o));

  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // read data compared against the oldest noted expectation
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) begin
      check(dat_o, exp_q.pop_front());
    end
  end

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ************************************************************
  // bus and measurement tasks
  // ************************************************************
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask

  // zero asks for a random magnitude well below the drop-out level
  function automatic logic [15:0] v(input logic [15:0] x);
    v = (x == 16'h0) ? 16'({$random(seed)} % 9000) : x;
  endfunction

  task automatic put(input logic [15:0] a, input logic [15:0] b,
                     input logic [15:0] c, input logic [15:0] n,
                     input logic [15:0] k);
    @(posedge clk_i);
    mag <= {v(c), v(b), v(a), v(n), v(n), v(n), v(k), v(k)};
  endtask

  // two updates pass so that values and blocking are surely taken
  task automatic upd();
    repeat (2) begin
      @(posedge clk_i);
      while (meas_valid_i !== 1'b1) @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`REG_CTRL, 32'h0);
    rd(`REG_FORCE, 32'h0);
    rd(`REG_THRESH, 32'h2904);
    upd();
    rd(`REG_PRIM_THR, 32'h41a);
    rd(`REG_EXP_TIME, 32'h8);
    rd(`REG_REMAIN, 32'h8);
    rd(8'h3c, 32'h0);
    wr(`REG_STATUS, 32'hff);
    rd(`REG_STATUS, 32'h0);
    wr(`REG_THRESH, 32'h2710);
    upd();
    rd(`REG_PRIM_THR, 32'h3e8);
    put(16'd10000, 0, 0, 0, 0);
    upd();
    rd(`REG_STATUS, 32'h0);
    put(16'd10001, 0, 0, 0, 0);
    upd();
    rd(`REG_STATUS, 32'h19);
    rd(`REG_RATIO_A, 32'h64);
    rd(`REG_RATIO_SEL, 32'h64);
    put(16'd9700, 0, 0, 0, 0);
    upd();
    rd(`REG_STATUS, 32'h19);
    put(16'd9699, 0, 0, 0, 0);
    upd();
    rd(`REG_STATUS, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(`REG_CTRL, 32'(c << 3));
      for (int n = 1; n <= 3; n++) begin
        put(16'd12000, (n > 1) ? 16'd12000 : 16'h0,
            (n > 2) ? 16'd12000 : 16'h0, 0, 0);
        upd();
        rd(`REG_STATUS, 32'((1 << n) - 1) |
           ((n >= ((c == 3) ? 3 : c + 1)) ? 32'h18 : 32'h0));
      end
    end
    wr(`REG_CTRL, 32'h0);
    put(16'd12000, 0, 0, 0, 0);
    block_req <= 1'b1;
    upd();
    rd(`REG_STATUS, 32'hc9);
    check({31'h0, start_o}, 32'h0);
    check({31'h0, blocked_o}, 32'h1);
    block_req <= 1'b0;
    upd();
    rd(`REG_STATUS, 32'h19);
    for (int i = 0; i < 6; i++) begin
      wr(`REG_CTRL, {29'h0, cfg[i]});
      put(0, 0, 0, 16'd12000, 16'd12000);
      upd();
      rd(`REG_STATUS, {24'h0, est[i]});
    end
    wr(`REG_CTRL, 32'h0);
    wr(`REG_THRESH, 32'h32c8);
    put(16'd12000, 16'd12000, 16'd12000, 0, 0);
    repeat (3) upd();
    rd(`REG_STATUS, 32'h0);
    wr(`REG_THRESH, 32'h2af8);
    upd();
    rd(`REG_PREFAULT, 32'h2ee0);
    put(0, 0, 0, 0, 0);
    upd();
    for (int f = 0; f < 4; f++) begin
      wr(`REG_FORCE, 32'(4 + f));
      repeat (3) @(posedge clk_i);
      check({29'h0, start_o, trip_o, blocked_o}, {29'h0, fexp[f]});
      rd(`REG_FORCE, 32'(4 + f));
    end
    wr(`REG_FORCE, 32'h2);
    repeat (3) @(posedge clk_i);
    check({29'h0, start_o, trip_o, blocked_o}, 32'h0);
    repeat (2) @(posedge clk_i);
    report_and_stop();
  end
endmodule
